// *** design/tte_pkg.sv ***
// ****************************************************************
// Timer trigger event counter constants
// ****************************************************************
package tte_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int TTE_CNT_W = 16;
   localparam int TTE_BYTE_W = 8;
   localparam int TTE_DIV_W = 11;

   // ****************************************************************
   // Internal source clock taps (fc/2^n)
   // ****************************************************************
   localparam int TTE_DIV_TAP_SLOW = 11;
   localparam int TTE_DIV_TAP_MID = 7;
   localparam int TTE_DIV_TAP_FAST = 3;

   // ****************************************************************
   // Source clock select codes
   // ****************************************************************
   localparam logic [1:0] TTE_SRC_DIV11 = 2'h0;
   localparam logic [1:0] TTE_SRC_DIV7 = 2'h1;
   localparam logic [1:0] TTE_SRC_DIV3 = 2'h2;
   localparam logic [1:0] TTE_SRC_PIN = 2'h3;

   // ****************************************************************
   // Operating mode select codes
   // ****************************************************************
   localparam logic [1:0] TTE_MODE_TIMER = 2'h0;
   localparam logic [1:0] TTE_MODE_WINDOW = 2'h1;
   localparam logic [1:0] TTE_MODE_PULSE = 2'h2;
   localparam logic [1:0] TTE_MODE_PPG = 2'h3;

   // ****************************************************************
   // Start control codes
   // ****************************************************************
   localparam logic [1:0] TTE_START_STOP = 2'h0;
   localparam logic [1:0] TTE_START_CMD = 2'h1;
   localparam logic [1:0] TTE_START_RISE = 2'h2;
   localparam logic [1:0] TTE_START_FALL = 2'h3;

   // ****************************************************************
   // Noise filter timing, in periods of fc (the clk input)
   // ****************************************************************
   localparam int TTE_FILT_REJECT_FC = 4;
   localparam int TTE_FILT_ACCEPT_FC = 12;
   localparam int TTE_FILT_THR_CYC = (TTE_FILT_REJECT_FC + TTE_FILT_ACCEPT_FC) / 2;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [15:0] TTE_CMP_RESET = 16'hFFFF;
   localparam logic [15:0] TTE_CAP_RESET = 16'h0000;

   // ****************************************************************
   // Counter states
   // ****************************************************************
   typedef enum logic [1:0] {
      TTE_STOPPED,
      TTE_ARMED,
      TTE_RUNNING
   } tte_state_type;

endpackage : tte_pkg

// *** design/tte_noise_filter.sv ***
`timescale 1ns/100ps
module tte_noise_filter
   import tte_pkg::*;
#(
   parameter int THR_CYC = TTE_FILT_THR_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic bypass,
   input wire logic pin_in,
   output logic pin_out
);

   localparam int CW = $clog2(THR_CYC + 1);

   // ****************************************************************
   // Parameter check
   // ****************************************************************
   if (THR_CYC < 2) begin : g_bad_thr
      $error("tte_noise_filter: THR_CYC must be at least 2");
   end

   typedef struct packed {
      logic [CW-1:0] run;
      logic level;
   } tte_filt_type;

   tte_filt_type r_q;
   tte_filt_type r_d;

   // ****************************************************************
   // Unless bypassed, level changes only after THR_CYC steady cycles of the new value
   // ****************************************************************
   always_comb begin
      r_d = r_q;
      if (bypass) begin
         r_d.level = pin_in; // RULE12
         r_d.run = '0;
      end else if (pin_in == r_q.level) begin
         r_d.run = '0;
      end else if (r_q.run == CW'(THR_CYC - 1)) begin
         r_d.level = pin_in; // RULE11
         r_d.run = '0;
      end else begin
         r_d.run = r_q.run + CW'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign pin_out = r_q.level;

endmodule : tte_noise_filter

// *** design/tte_timer.sv ***
// How it works
// RULE1: six modes chosen by mode select field; only the three code 00 modes are built, the other codes leave the counter idle
// RULE2: timer counts ticks, match interrupts and clears
// RULE3: auto capture copies counter each source tick
// RULE4: read capture only while running and enabled
// RULE5: wait one source tick before first read
// RULE6: external trigger edge starts counting ticks
// RULE7: trigger mode match clears, halts, interrupts
// RULE8: stop select 1: opposite edge clears, halts
// RULE9: stop select 1: next trigger restarts count
// RULE10: stop select 0: ignore opposite, retrigger edges
// RULE11: pin filter rejects short, keeps long pulses
// RULE12: low speed bypasses filter, pulse one cycle
// RULE13: event mode counts selected pin edges only
// RULE14: event match checked on opposite edge, clears
// RULE15: source holds pin levels two machine cycles
// RULE16: event mode auto capture copies continuously
// RULE17: source select picks divider tap or pin
// RULE18: mode code 00 holds these three modes
// RULE19: reconfigure only while start control stopped
// RULE20: sixteen bit value loads after upper byte
// RULE21: counter, compare, capture sixteen bits wide
`timescale 1ns/100ps
module tte_timer
   import tte_pkg::*;
#(
   parameter int CNT_W = TTE_CNT_W,
   parameter int FILT_THR_CYC = TTE_FILT_THR_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] start_control,
   input wire logic [1:0] operating_mode_select,
   input wire logic [1:0] source_clock_select,
   input wire logic auto_capture_enable,
   input wire logic trigger_stop_select,
   input wire logic divider_clock_select,
   input wire logic low_speed_mode,
   input wire logic fs_tick,
   input wire logic timer_input_pin,
   input wire logic [7:0] cmp_wdata,
   input wire logic cmp_wr_lo,
   input wire logic cmp_wr_hi,
   input wire logic [7:0] cap_wdata,
   input wire logic cap_wr_lo,
   input wire logic cap_wr_hi,
   output logic [15:0] compare_period_reg,
   output logic [15:0] capture_reg,
   output logic [15:0] counter_value,
   output logic timer_match_irq,
   output logic counting
);

   // ****************************************************************
   // Parameter check
   // ****************************************************************
   if (CNT_W != 2 * TTE_BYTE_W) begin : g_bad_width
      $error("tte_timer: CNT_W must be two bytes wide");
   end

   if (FILT_THR_CYC <= TTE_FILT_REJECT_FC || FILT_THR_CYC > TTE_FILT_ACCEPT_FC) begin : g_bad_filt
      $error("tte_timer: FILT_THR_CYC outside the reject and accept bounds");
   end

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      tte_state_type st;
      logic [TTE_DIV_W-1:0] div;
      logic pin_prev;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] cmp;
      logic [TTE_BYTE_W-1:0] cmp_lo;
      logic cmp_pend;
      logic [CNT_W-1:0] cmp_stage;
      logic [CNT_W-1:0] cap;
      logic [TTE_BYTE_W-1:0] cap_lo;
      logic cap_pend;
      logic [CNT_W-1:0] cap_stage;
      logic irq;
      logic running;
   } tte_regs_type;

   tte_regs_type r_q;
   tte_regs_type r_d;

   logic pin_filt;

   // ****************************************************************
   // Input noise filter
   // ****************************************************************
   // Filter and edge register reset low, matching an idle low pin
   tte_noise_filter #(
      .THR_CYC(FILT_THR_CYC)
   ) u_filter (
      .clk(clk),
      .rst(rst),
      .bypass(low_speed_mode),
      .pin_in(timer_input_pin),
      .pin_out(pin_filt)
   );

   // ****************************************************************
   // Decode
   // ****************************************************************
   logic div11_tick;
   logic div7_tick;
   logic div3_tick;
   logic pin_rise;
   logic pin_fall;
   logic trig_edge;
   logic opp_edge;
   logic src_tick;
   logic mode_enabled;
   logic event_mode;
   logic extrig_mode;
   logic cnt_match;
   logic [2:0] tap_tick;

   // ****************************************************************
   // Divider taps, slowest first
   // ****************************************************************
   for (genvar i = 0; i < 3; i++) begin : g_tap
      localparam int SPAN = (i == 0) ? TTE_DIV_TAP_SLOW : ((i == 1) ? TTE_DIV_TAP_MID : TTE_DIV_TAP_FAST);
      assign tap_tick[i] = &r_q.div[SPAN-1:0];
   end

   always_comb begin
      div11_tick = tap_tick[0];
      div7_tick = tap_tick[1];
      div3_tick = tap_tick[2];
      pin_rise = pin_filt & ~r_q.pin_prev;
      pin_fall = ~pin_filt & r_q.pin_prev;
      // Falling codes use the falling edge as trigger or count edge
      trig_edge = (start_control == TTE_START_FALL) ? pin_fall : pin_rise;
      opp_edge = (start_control == TTE_START_FALL) ? pin_rise : pin_fall;
      // Window, pulse width and pulse output codes leave the counter idle
      mode_enabled = (operating_mode_select == TTE_MODE_TIMER) && (start_control != TTE_START_STOP); // RULE1 RULE18
      event_mode = mode_enabled && start_control[1] && (source_clock_select == TTE_SRC_PIN);
      extrig_mode = mode_enabled && start_control[1] && (source_clock_select != TTE_SRC_PIN);
      cnt_match = (r_q.cnt == r_q.cmp); // RULE21
   end

   // ****************************************************************
   // Source tick select
   // ****************************************************************
   always_comb begin
      unique case (source_clock_select) // RULE17
         TTE_SRC_DIV11: begin
            src_tick = (divider_clock_select | low_speed_mode) ? fs_tick : div11_tick;
         end
         TTE_SRC_DIV7: begin
            src_tick = div7_tick & ~low_speed_mode;
         end
         TTE_SRC_DIV3: begin
            src_tick = div3_tick & ~low_speed_mode;
         end
         TTE_SRC_PIN: begin
            src_tick = trig_edge;
         end
      endcase
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      r_d = r_q;
      r_d.div = r_q.div + TTE_DIV_W'(1);
      r_d.pin_prev = pin_filt;
      r_d.irq = 1'b0;

      // Byte writes: low byte is staged, high byte arms the load
      if (cmp_wr_lo) begin
         r_d.cmp_lo = cmp_wdata;
      end
      if (cmp_wr_hi) begin
         r_d.cmp_stage = {cmp_wdata, (cmp_wr_lo ? cmp_wdata : r_q.cmp_lo)};
         r_d.cmp_pend = 1'b1;
      end
      if (cap_wr_lo) begin
         r_d.cap_lo = cap_wdata;
      end
      if (cap_wr_hi) begin
         r_d.cap_stage = {cap_wdata, (cap_wr_lo ? cap_wdata : r_q.cap_lo)};
         r_d.cap_pend = 1'b1;
      end
      // Staged values take effect on the next source tick
      if (src_tick && r_q.cmp_pend && !cmp_wr_hi) begin
         r_d.cmp = r_q.cmp_stage; // RULE20
         r_d.cmp_pend = 1'b0;
      end
      if (src_tick && r_q.cap_pend && !cap_wr_hi) begin
         r_d.cap = r_q.cap_stage; // RULE20
         r_d.cap_pend = 1'b0;
      end

      if (!mode_enabled) begin
         // Stop and clear; configuration may change only here
         r_d.st = TTE_STOPPED; // RULE19
         r_d.cnt = '0;
      end else if (event_mode) begin
         r_d.st = TTE_RUNNING;
         // Count edge and match edge never fall in one cycle
         if (trig_edge) begin
            r_d.cnt = r_q.cnt + CNT_W'(1); // RULE13
         end else if (opp_edge && cnt_match) begin
            r_d.cnt = '0; // RULE14
            r_d.irq = 1'b1;
         end
         if (auto_capture_enable) begin
            r_d.cap = r_q.cnt; // RULE16
         end
      end else if (extrig_mode) begin
         unique case (r_q.st)
            TTE_STOPPED, TTE_ARMED: begin
               // Held at zero until the trigger edge arrives
               r_d.cnt = '0;
               if (trig_edge) begin
                  r_d.st = TTE_RUNNING; // RULE6 RULE9
               end else begin
                  r_d.st = TTE_ARMED;
               end
            end
            TTE_RUNNING: begin
               // Opposite edge wins over a tick in the same cycle
               if (trigger_stop_select && opp_edge) begin
                  r_d.cnt = '0; // RULE8
                  r_d.st = TTE_ARMED;
               end else if (src_tick) begin
                  // Retrigger edges are not looked at while running
                  if (cnt_match) begin
                     r_d.cnt = '0; // RULE7 RULE10
                     r_d.st = TTE_ARMED;
                     r_d.irq = 1'b1;
                  end else begin
                     r_d.cnt = r_q.cnt + CNT_W'(1); // RULE6
                  end
               end
            end
            default: begin
               r_d.st = TTE_STOPPED;
               r_d.cnt = '0;
            end
         endcase
      end else begin
         // Command start: free running timer
         r_d.st = TTE_RUNNING;
         if (src_tick) begin
            if (cnt_match) begin
               r_d.cnt = '0; // RULE2
               r_d.irq = 1'b1;
            end else begin
               r_d.cnt = r_q.cnt + CNT_W'(1); // RULE2
            end
            if (auto_capture_enable) begin
               // Capture takes the value held before this tick
               r_d.cap = r_q.cnt; // RULE3
            end
         end
      end

      // Registered copy of the running state for the output
      r_d.running = (r_d.st == TTE_RUNNING);
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_q <= '{
            st: TTE_STOPPED,
            div: '0,
            pin_prev: 1'b0,
            cnt: '0,
            cmp: TTE_CMP_RESET,
            cmp_lo: '0,
            cmp_pend: 1'b0,
            cmp_stage: '0,
            cap: TTE_CAP_RESET,
            cap_lo: '0,
            cap_pend: 1'b0,
            cap_stage: '0,
            irq: 1'b0,
            running: 1'b0
         };
      end else begin
         r_q <= r_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign compare_period_reg = r_q.cmp;
   assign capture_reg = r_q.cap;
   assign counter_value = r_q.cnt;
   assign timer_match_irq = r_q.irq;
   assign counting = r_q.running;

endmodule : tte_timer

// *** tb/tte_timer_assertions.sv ***
`timescale 1ns/100ps
module tte_timer_assertions
   import tte_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] start_control,
   input wire logic [1:0] operating_mode_select,
   input wire logic [1:0] source_clock_select,
   input wire logic auto_capture_enable,
   input wire logic [15:0] compare_period_reg,
   input wire logic [15:0] capture_reg,
   input wire logic [15:0] counter_value,
   input wire logic timer_match_irq,
   input wire logic counting
);
   // ****************************************************************
   // Counter, interrupt and capture checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_irq_pulse;
      timer_match_irq |=> !timer_match_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than one cycle");
   property p_irq_clear;
      timer_match_irq |-> counter_value == 16'h0000;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("counter not cleared on irq");
   property p_irq_match;
      timer_match_irq |-> $past(counter_value) == $past(compare_period_reg);
   endproperty
   a_irq_match: assert property (p_irq_match) else $error("irq without full compare match");
   property p_irq_halt;
      (timer_match_irq && start_control[1] && source_clock_select != TTE_SRC_PIN) |-> !counting;
   endproperty
   a_irq_halt: assert property (p_irq_halt) else $error("trigger timer not halted on match");
   property p_stop;
      start_control == TTE_START_STOP |=> counter_value == 16'h0000 && !counting;
   endproperty
   a_stop: assert property (p_stop) else $error("counter not stopped and cleared");
   property p_mode;
      operating_mode_select != TTE_MODE_TIMER |=> counter_value == 16'h0000 && !timer_match_irq;
   endproperty
   a_mode: assert property (p_mode) else $error("counter active in unbuilt mode");
   property p_step;
      counter_value != $past(counter_value) |->
         counter_value == $past(counter_value) + 16'h0001 || counter_value == 16'h0000;
   endproperty
   a_step: assert property (p_step) else $error("counter jumped");
   property p_cap_timer;
      ($past(auto_capture_enable) && $past(start_control) == TTE_START_CMD && counter_value != $past(counter_value))
         |-> capture_reg == $past(counter_value);
   endproperty
   a_cap_timer: assert property (p_cap_timer) else $error("timer capture wrong");
   property p_cap_event;
      ($past(auto_capture_enable) && $past(source_clock_select) == TTE_SRC_PIN && $past(start_control[1]))
         |-> capture_reg == $past(counter_value);
   endproperty
   a_cap_event: assert property (p_cap_event) else $error("event capture wrong");
endmodule : tte_timer_assertions

// *** tb/tte_pulse_source.sv ***
`timescale 1ns/100ps
module tte_pulse_source (
   input wire logic clk,
   output logic pin
);
   // ****************************************************************
   // Pulse of given high and low lengths, stepped at falling edges
   // ****************************************************************
   initial pin = 1'b0;
   task automatic pulse(input int hi_cyc, input int lo_cyc);
      pin = 1'b1;
      repeat (hi_cyc) @(negedge clk);
      pin = 1'b0;
      repeat (lo_cyc) @(negedge clk);
   endtask : pulse
endmodule : tte_pulse_source

// *** tb/timer_trigger_event_counter_tb.sv ***
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module timer_trigger_event_counter_tb
   import tte_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] start_control = TTE_START_STOP;
   logic [1:0] operating_mode_select = TTE_MODE_TIMER;
   logic [1:0] source_clock_select = TTE_SRC_DIV3;
   logic auto_capture_enable = 1'b0;
   logic trigger_stop_select = 1'b0;
   logic divider_clock_select = 1'b0;
   logic low_speed_mode = 1'b0;
   logic fs_tick = 1'b0;
   logic timer_input_pin;
   logic [7:0] cmp_wdata = 8'h00;
   logic cmp_wr_lo = 1'b0;
   logic cmp_wr_hi = 1'b0;
   logic [7:0] cap_wdata = 8'h00;
   logic cap_wr_lo = 1'b0;
   logic cap_wr_hi = 1'b0;
   logic [15:0] compare_period_reg, capture_reg, counter_value;
   logic timer_match_irq, counting;
   logic [2:0] fs_cnt = 3'h0;
   int n_mismatch = 0;
   int checks = 0;
   int n_irq = 0;
   int k;
   int waited;
   tte_timer dut (.clk(clk), .rst(rst), .start_control(start_control),
      .operating_mode_select(operating_mode_select), .source_clock_select(source_clock_select),
      .auto_capture_enable(auto_capture_enable), .trigger_stop_select(trigger_stop_select),
      .divider_clock_select(divider_clock_select), .low_speed_mode(low_speed_mode), .fs_tick(fs_tick),
      .timer_input_pin(timer_input_pin), .cmp_wdata(cmp_wdata), .cmp_wr_lo(cmp_wr_lo), .cmp_wr_hi(cmp_wr_hi),
      .cap_wdata(cap_wdata), .cap_wr_lo(cap_wr_lo), .cap_wr_hi(cap_wr_hi), .compare_period_reg(compare_period_reg),
      .capture_reg(capture_reg), .counter_value(counter_value), .timer_match_irq(timer_match_irq),
      .counting(counting));
   tte_pulse_source src (.clk(clk), .pin(timer_input_pin));
   always #25 clk = ~clk;
   always @(negedge clk) begin
      fs_cnt <= fs_cnt + 3'h1;
      fs_tick <= (fs_cnt == 3'h7);
   end
   always @(posedge clk) begin
      if (timer_match_irq === 1'b1) begin
         n_irq++;
      end
   end
   // ****************************************************************
   // Access tasks
   // ****************************************************************
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task tally_and_finish;
      if (n_mismatch == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   // Low byte then high byte, then room for a source tick to load it
   task automatic wr16(input logic sel, input logic [15:0] v);
      cmp_wdata = v[7:0];
      cap_wdata = v[7:0];
      cmp_wr_lo = ~sel;
      cap_wr_lo = sel;
      cyc(1);
      cmp_wr_lo = 1'b0;
      cap_wr_lo = 1'b0;
      cmp_wdata = v[15:8];
      cap_wdata = v[15:8];
      cmp_wr_hi = ~sel;
      cap_wr_hi = sel;
      cyc(1);
      cmp_wr_hi = 1'b0;
      cap_wr_hi = 1'b0;
      cyc(20);
   endtask : wr16
   task automatic wait_irq(input int lim);
      k = n_irq;
      for (waited = 0; waited < lim && n_irq == k; waited++) begin
         @(negedge clk);
      end
      if (n_irq == k) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask : wait_irq
   initial begin
      cyc(6);
      rst = 1'b0;
      `CHK(compare_period_reg, TTE_CMP_RESET)
      `CHK(capture_reg, TTE_CAP_RESET)
      wr16(1'b1, 16'h1234);
      `CHK(capture_reg, 16'h1234)
      wr16(1'b0, 16'h0003);
      cmp_wdata = 8'h55;
      cmp_wr_lo = 1'b1;
      cyc(1);
      cmp_wr_lo = 1'b0;
      cyc(20);
      `CHK(compare_period_reg, 16'h0003)
      auto_capture_enable = 1'b1;
      start_control = TTE_START_CMD;
      wait_irq(100);
      `CHK(counter_value, 16'h0000)
      `CHK(capture_reg, 16'h0003)
      `CHK(counting, 1'b1)
      wait_irq(100);
      `CHK(waited, 32)
      start_control = TTE_START_STOP;
      cyc(2);
      `CHK(counting, 1'b0)
      for (int m = 1; m < 4; m++) begin
         operating_mode_select = m[1:0];
         cyc(1);
         start_control = TTE_START_CMD;
         cyc(20);
         `CHK(counter_value, 16'h0000)
         `CHK(counting, 1'b0)
         start_control = TTE_START_STOP;
         cyc(1);
      end
      operating_mode_select = TTE_MODE_TIMER;
      auto_capture_enable = 1'b0;
      cyc(1);
      start_control = TTE_START_RISE;
      k = n_irq;
      src.pulse(4, 60);
      `CHK(n_irq, k)
      src.pulse(12, 50);
      `CHK(n_irq, k + 1)
      start_control = TTE_START_STOP;
      trigger_stop_select = 1'b1;
      cyc(1);
      start_control = TTE_START_RISE;
      src.pulse(16, 30);
      `CHK(n_irq, k + 1)
      `CHK(counter_value, 16'h0000)
      src.pulse(60, 20);
      `CHK(n_irq, k + 2)
      `CHK(counting, 1'b0)
      start_control = TTE_START_STOP;
      low_speed_mode = 1'b1;
      divider_clock_select = 1'b1;
      source_clock_select = TTE_SRC_DIV11;
      trigger_stop_select = 1'b0;
      cyc(1);
      start_control = TTE_START_RISE;
      src.pulse(4, 60);
      `CHK(n_irq, k + 3)
      start_control = TTE_START_STOP;
      low_speed_mode = 1'b0;
      divider_clock_select = 1'b0;
      source_clock_select = TTE_SRC_DIV3;
      wr16(1'b0, 16'h0002);
      source_clock_select = TTE_SRC_PIN;
      auto_capture_enable = 1'b1;
      cyc(1);
      start_control = TTE_START_RISE;
      k = n_irq;
      repeat (3) src.pulse(12, 12);
      cyc(20);
      `CHK(n_irq, k + 1)
      `CHK(counter_value, 16'h0001)
      `CHK(capture_reg, 16'h0001)
      start_control = TTE_START_STOP;
      cyc(1);
      start_control = TTE_START_FALL;
      src.pulse(12, 12);
      `CHK(counter_value, 16'h0001)
      `CHK(counting, 1'b1)
      start_control = TTE_START_STOP;
      auto_capture_enable = 1'b0;
      source_clock_select = TTE_SRC_DIV7;
      cyc(1);
      start_control = TTE_START_CMD;
      wait_irq(400);
      wait_irq(400);
      `CHK(waited, 384)
      start_control = TTE_START_STOP;
      source_clock_select = TTE_SRC_DIV11;
      cyc(1);
      start_control = TTE_START_CMD;
      wait_irq(6200);
      wait_irq(6200);
      `CHK(waited, 6144)
      tally_and_finish();
   end
endmodule : timer_trigger_event_counter_tb
bind tte_timer tte_timer_assertions u_chk (.clk(clk), .rst(rst), .start_control(start_control),
   .operating_mode_select(operating_mode_select), .source_clock_select(source_clock_select),
   .auto_capture_enable(auto_capture_enable), .compare_period_reg(compare_period_reg), .capture_reg(capture_reg),
   .counter_value(counter_value), .timer_match_irq(timer_match_irq), .counting(counting));
